/* File: core/tcc_timer_ctrl.sv */
// Purpose: Count source selection, status flags, underflow reload and capture
// Assumes: All inputs synchronous to sys_clk_i except the timer clock pin
// Notes:   Reload values and start bits enter as ports; counters are bus-writable
//          Map: controls 00 to 10, capture value 14, counters 18 to 28
//          A counter write beats a count in the same cycle; stop the channel first
//
// Function
// (R1) Capture flag sets on capture; write 0 clears
// (R2) Underflow flag sets on underflow; write 0 clears
// (R3) Capture control: off, reserved, on, on+irq
// (R4) One DMA request per capture, wait service; a capture that arrives while a request is still pending gets no request
// (R5) Capture value copied only while flag clear
// (R6) Underflow enable gates underflow interrupt
// (R7) Edge select: rising, falling, both edges
// (R8) Edge select only on channels zero to two
// (R9) Prescale code picks divider, RTC or pin
// (R10) Software never selects RTC/pin on 3,4
// (R11) Standby stops all but RTC channels 0-2
// (R12) Reserved bits read zero, writes ignored
// (R13) Channels 3,4 hold flag, enable, prescale
// (R14) Software sets pin as input first
// (R15) 32-bit read-only capture value, channel 2
// (R16) Capture value keeps contents through reset
// (R17) Control fields reset to zero
// (R18) Underflow reloads counter from reload value
// (R19) Capture irq while flag set, control 11
// (R20) Pin synchronised before edge detection
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_ctrl (
  input  wire logic          sys_clk_i,        // Peripheral clock
  input  wire logic          rst_i,            // Synchronous reset, high
  input  wire logic [7:0]    addr_i,           // Register byte address
  input  wire logic [31:0]   wr_data_i,        // Write data
  input  wire logic          wr_i,             // Write strobe
  input  wire logic          rd_i,             // Read strobe
  output logic      [31:0]   rd_data_o,        // Read data, cycle after strobe
  input  wire logic [4:0]    start_i,          // Per-channel count run
  input  wire logic [159:0]  reload_i,         // Per-channel reload values
  input  wire logic          rtc_tick_i,       // RTC count pulse
  input  wire logic          timer_clock_pin_i,// Pin, asynchronous
  input  wire logic          standby_i,        // Module standby level
  input  wire logic          dma_ack_i,        // DMA request serviced
  output logic               dma_req_o,        // DMA transfer request
  output logic               capture_irq_o,    // Capture interrupt level
  output logic      [4:0]    underflow_irq_o,  // Underflow interrupt levels
  output logic      [159:0]  counter_o         // Per-channel counters
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0]        pre;
    logic [2:0]        pin_sync;
    logic [4:0][15:0]  ctrl;
    logic [4:0][31:0]  cnt;
    logic [31:0]       capv;
    logic              dma_req;
    logic [31:0]       rdata;
  } tcc_state_s;

  tcc_state_s st;
  tcc_state_s next_st;

  localparam tcc_state_s ST_RST = '{
    pre:      '0,
    pin_sync: '0,
    ctrl:     {5{tcc_pkg::RST_CTRL}},
    cnt:      {5{tcc_pkg::RST_CNT}},
    capv:     '0,
    dma_req:  1'b0,
    rdata:    '0
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] impl_mask(input int unsigned ch);
    if (ch == tcc_pkg::CAP_CH) begin
      impl_mask = tcc_pkg::MASK_CTRL_CAP;
    end else if (ch < tcc_pkg::CAP_CH) begin
      impl_mask = tcc_pkg::MASK_CTRL_PLAIN;
    end else begin
      impl_mask = tcc_pkg::MASK_CTRL_SMALL;
    end
  endfunction : impl_mask

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       cur,
                                    input logic       prev);
    case (sel)
      tcc_pkg::EDGE_RISE: edge_hit = cur & ~prev;
      tcc_pkg::EDGE_FALL: edge_hit = ~cur & prev;
      default:            edge_hit = cur ^ prev;
    endcase
  endfunction : edge_hit

  // Divider codes tick when the low bits of the free prescaler are all ones
  function automatic logic div_tick(input logic [2:0] code,
                                    input logic [9:0] pre);
    case (code)
      tcc_pkg::PSC_DIV4:    div_tick = &pre[1:0];
      tcc_pkg::PSC_DIV16:   div_tick = &pre[3:0];
      tcc_pkg::PSC_DIV64:   div_tick = &pre[5:0];
      tcc_pkg::PSC_DIV256:  div_tick = &pre[7:0];
      tcc_pkg::PSC_DIV1024: div_tick = &pre[9:0];
      default:              div_tick = 1'b0;
    endcase
  endfunction : div_tick

  logic [4:0]  tick;
  logic        cap_on;
  logic        cap_ev;
  logic        cap_flag;
  logic [1:0]  cap_edge;
  logic [2:0]  psc [5];
  logic [4:0]  ctrl_wr;
  logic [4:0]  cnt_wr;
  logic [15:0] wmask;
  logic [1:0]  capc;
  tcc_state_s  reset_st;

  always_comb begin
    next_st  = st;
    reset_st = ST_RST;
    wmask    = '0;
    cnt_wr   = '0;
    next_st.pre = st.pre + 10'h001;

    // ----------------------------------------------------------------
    // Pin synchroniser and capture decode
    // ----------------------------------------------------------------
    // (R20) Two-stage sync, edge on stages two/three
    next_st.pin_sync = {st.pin_sync[1:0], timer_clock_pin_i};

    capc     = st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_CAP_HI:tcc_pkg::BIT_CAP_LO];
    cap_flag = st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_CAP_FLAG];
    cap_edge = st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_EDGE_HI:tcc_pkg::BIT_EDGE_LO];
    // (R3) Only codes 10 and 11 turn capture on
    cap_on = (capc == tcc_pkg::CAPC_ON_NOIRQ) || (capc == tcc_pkg::CAPC_ON_IRQ);
    // (R7) Edge chosen by channel two select
    cap_ev = cap_on & ~standby_i & edge_hit(cap_edge, st.pin_sync[1], st.pin_sync[2]);

    // ----------------------------------------------------------------
    // Per-channel count source, control and counter
    // ----------------------------------------------------------------
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      psc[i] = st.ctrl[i][tcc_pkg::BIT_PSC_HI:0];
      // (R9) Prescale code to count tick
      case (psc[i])
        // (R8) RTC and pin sources on channels 0-2 only
        tcc_pkg::PSC_RTC:     tick[i] = (i <= tcc_pkg::CAP_CH) & rtc_tick_i;
        tcc_pkg::PSC_PIN:     tick[i] = (i <= tcc_pkg::CAP_CH) &
                                        edge_hit(st.ctrl[i][tcc_pkg::BIT_EDGE_HI:
                                                            tcc_pkg::BIT_EDGE_LO],
                                                 st.pin_sync[1], st.pin_sync[2]);
        // Reserved code 5 yields no tick
        default:              tick[i] = div_tick(psc[i], st.pre);
      endcase
      // (R11) Standby keeps only RTC channels running
      if (standby_i && !((psc[i] == tcc_pkg::PSC_RTC) && (i <= tcc_pkg::CAP_CH))) begin
        tick[i] = 1'b0;
      end

      ctrl_wr[i] = wr_i && (addr_i == tcc_pkg::OFF_CTRL0 + 8'(i) * tcc_pkg::OFF_STRIDE);
      cnt_wr[i]  = wr_i && (addr_i == tcc_pkg::OFF_CNT0 + 8'(i) * tcc_pkg::OFF_STRIDE);
      if (ctrl_wr[i]) begin
        wmask = impl_mask(i);
        // (R12) Reserved and absent bits never stored
        next_st.ctrl[i] = wr_data_i[15:0] & wmask;
        // (R1) Writing 1 leaves capture flag as is
        next_st.ctrl[i][tcc_pkg::BIT_CAP_FLAG] = st.ctrl[i][tcc_pkg::BIT_CAP_FLAG] &
            (wr_data_i[tcc_pkg::BIT_CAP_FLAG] | ~wmask[tcc_pkg::BIT_CAP_FLAG]);
        // (R2) Writing 1 leaves underflow flag as is
        next_st.ctrl[i][tcc_pkg::BIT_UNF_FLAG] = st.ctrl[i][tcc_pkg::BIT_UNF_FLAG] &
            wr_data_i[tcc_pkg::BIT_UNF_FLAG];
      end

      // Software preload wins; an underflow in that cycle is lost
      if (cnt_wr[i]) begin
        next_st.cnt[i] = wr_data_i;
      end else if (start_i[i] && tick[i]) begin
        if (st.cnt[i] == '0) begin
          // (R18) Reload from reload value on underflow
          next_st.cnt[i] = reload_i[i*32 +: 32];
          // (R2) Underflow sets flag, beats clear
          next_st.ctrl[i][tcc_pkg::BIT_UNF_FLAG] = 1'b1;
        end else begin
          next_st.cnt[i] = st.cnt[i] - 32'h00000001;
        end
      end
    end

    if (cap_ev) begin
      // (R5) Copy counter only while flag clear
      if (!cap_flag) begin
        next_st.capv = st.cnt[tcc_pkg::CAP_CH];
      end
      // (R1) Capture sets flag, beats clear
      next_st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_CAP_FLAG] = 1'b1;
    end

    // ----------------------------------------------------------------
    // DMA request
    // ----------------------------------------------------------------
    // (R4) New request only once previous serviced
    next_st.dma_req = (st.dma_req & ~dma_ack_i) | (cap_ev & ~st.dma_req);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Unmapped addresses read zero
    next_st.rdata = '0;
    if (rd_i) begin
      for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
        // (R13) Absent bits of channels 3,4 read zero
        if (addr_i == tcc_pkg::OFF_CTRL0 + 8'(i * 4)) begin
          next_st.rdata = {16'h0000, st.ctrl[i] & impl_mask(i)};
        end
        if (addr_i == tcc_pkg::OFF_CNT0 + 8'(i * 4)) begin
          next_st.rdata = st.cnt[i];
        end
      end
      // (R15) Read-only capture value register
      if (addr_i == tcc_pkg::OFF_CAPVAL) begin
        next_st.rdata = st.capv;
      end
    end

    // ----------------------------------------------------------------
    // Reset image
    // ----------------------------------------------------------------
    // (R16) Capture value survives reset
    reset_st.capv = st.capv;
    // Synchroniser keeps tracking the pin so release sees no false edge
    reset_st.pin_sync = next_st.pin_sync;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      // (R17) Control fields come out of reset at zero
      st <= reset_st;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o = st.rdata;
  assign dma_req_o = st.dma_req;
  assign counter_o = st.cnt;
  // (R19) Capture irq: flag set and control 11
  assign capture_irq_o = st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_CAP_FLAG] &&
      (st.ctrl[tcc_pkg::CAP_CH][tcc_pkg::BIT_CAP_HI:tcc_pkg::BIT_CAP_LO] ==
       tcc_pkg::CAPC_ON_IRQ);

  generate
    for (genvar g = 0; g < tcc_pkg::NUM_CH; g++) begin : g_unf_irq
      // (R6) Enable gates underflow interrupt
      assign underflow_irq_o[g] = st.ctrl[g][tcc_pkg::BIT_UNF_FLAG] &
                                  st.ctrl[g][tcc_pkg::BIT_UNF_IE];
    end
  endgenerate
endmodule : tcc_timer_ctrl
`default_nettype wire

/* File: core/tcc_pkg.sv */
// Purpose: Shared constants for the timer channel control and capture block
// Assumes: 100 MHz peripheral clock, plain register port with 8-bit byte address
// Notes:   Offsets are byte addresses of 32-bit words
package tcc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH    = 5;
  localparam int unsigned CAP_CH    = 2;
  localparam int unsigned CNT_W     = 32;
  localparam int unsigned CTRL_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned PRE_W     = 10;
  localparam real         CLK_MHZ   = 100.0;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0   = 8'h00;
  localparam logic [7:0] OFF_CTRL1   = 8'h04;
  localparam logic [7:0] OFF_CTRL2   = 8'h08;
  localparam logic [7:0] OFF_CTRL3   = 8'h0C;
  localparam logic [7:0] OFF_CTRL4   = 8'h10;
  localparam logic [7:0] OFF_CAPVAL  = 8'h14;
  localparam logic [7:0] OFF_CNT0    = 8'h18;
  localparam logic [7:0] OFF_STRIDE  = 8'h04;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CAP_FLAG  = 9;
  localparam int unsigned BIT_UNF_FLAG  = 8;
  localparam int unsigned BIT_CAP_HI    = 7;
  localparam int unsigned BIT_CAP_LO    = 6;
  localparam int unsigned BIT_UNF_IE    = 5;
  localparam int unsigned BIT_EDGE_HI   = 4;
  localparam int unsigned BIT_EDGE_LO   = 3;
  localparam int unsigned BIT_PSC_HI    = 2;

  // Implemented bits per channel type
  localparam logic [15:0] MASK_CTRL_PLAIN = 16'h013F;
  localparam logic [15:0] MASK_CTRL_CAP   = 16'h03FF;
  localparam logic [15:0] MASK_CTRL_SMALL = 16'h0127;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [31:0] RST_CNT  = 32'hFFFFFFFF;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PSC_DIV4    = 3'h0;
  localparam logic [2:0] PSC_DIV16   = 3'h1;
  localparam logic [2:0] PSC_DIV64   = 3'h2;
  localparam logic [2:0] PSC_DIV256  = 3'h3;
  localparam logic [2:0] PSC_DIV1024 = 3'h4;
  localparam logic [2:0] PSC_RTC     = 3'h6;
  localparam logic [2:0] PSC_PIN     = 3'h7;
  localparam logic [1:0] CAPC_ON_NOIRQ = 2'h2;
  localparam logic [1:0] CAPC_ON_IRQ   = 2'h3;
  localparam logic [1:0] EDGE_RISE     = 2'h0;
  localparam logic [1:0] EDGE_FALL     = 2'h1;
endpackage : tcc_pkg

/* File: verif/tcc_timer_ctrl_props.sv */
// Purpose: Port assertions for tcc_timer_ctrl
// Assumes: One clock, sync reset
// Notes:   Underflow checks are on channel 0 only
`timescale 1ns/1ns
`default_nettype none
module tcc_props (
  input wire logic         sys_clk_i,         // Clock
  input wire logic         rst_i,             // Reset
  input wire logic         wr_i,              // Write
  input wire logic         rd_i,              // Read
  input wire logic [7:0]   addr_i,            // Address
  input wire logic [31:0]  wr_data_i,         // Write data
  input wire logic [31:0]  rd_data_o,         // Read data
  input wire logic [4:0]   start_i,           // Run
  input wire logic [159:0] reload_i,          // Reloads
  input wire logic         timer_clock_pin_i, // Pin
  input wire logic         dma_ack_i,         // Service
  input wire logic         dma_req_o,         // Request
  input wire logic         capture_irq_o,     // Capture irq
  input wire logic [4:0]   underflow_irq_o,   // Underflow irqs
  input wire logic [159:0] counter_o          // Counters
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data outside read slot");
  dma_hold_a: assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
    else $error("dma request dropped unserviced");
  dma_drop_a: assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
    else $error("dma request kept after service");
  dma_cause_a: assert property ($rose(dma_req_o) |->
    $past(timer_clock_pin_i, 1) != $past(timer_clock_pin_i, 6))
    else $error("dma request without pin edge");
  cnt_step_a: assert property ($changed(counter_o[31:0]) |->
    counter_o[31:0] == $past(counter_o[31:0]) - 32'h1 ||
    counter_o[31:0] == $past(reload_i[31:0]) ||
    ($past(wr_i && addr_i == tcc_pkg::OFF_CNT0) && counter_o[31:0] == $past(wr_data_i)))
    else $error("counter moved by other than one step");
  cnt_hold_a: assert property (!start_i[0] && !(wr_i && addr_i == tcc_pkg::OFF_CNT0) |=>
    $stable(counter_o[31:0]))
    else $error("stopped counter moved");
  cirq_fall_a: assert property ($fell(capture_irq_o) |-> $past(wr_i))
    else $error("capture irq fell without write");
  uirq_rise_a: assert property ($rose(underflow_irq_o[0]) |->
    $past(wr_i) || $past(counter_o[31:0]) == 32'h0)
    else $error("underflow irq without cause");
endmodule : tcc_props
bind tcc_timer_ctrl tcc_props tcc_props_inst (.sys_clk_i, .rst_i, .wr_i, .rd_i, .addr_i, .wr_data_i,
  .rd_data_o, .start_i, .reload_i, .timer_clock_pin_i, .dma_ack_i, .dma_req_o,
  .capture_irq_o, .underflow_irq_o, .counter_o);
`default_nettype wire

/* File: verif/tcc_dma_model.sv */
// Purpose: DMA controller that services capture requests
// Assumes: Request held until the one-cycle service pulse
// Notes:   Service count survives reset on purpose
`timescale 1ns/1ns
`default_nettype none
module tcc_dma_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       rst_i,   // Reset
  input  wire logic       req_i,   // Request
  input  wire logic [3:0] delay_i, // Latency
  output logic            ack_o,   // Service pulse
  output int unsigned     served_o // Services done
);
  logic [3:0] wait_q;
  initial begin
    ack_o = 1'b0;
    served_o = 0;
    wait_q = 4'h0;
  end
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (rst_i) begin
      wait_q <= 4'h0;
    end else if (req_i && !ack_o) begin
      if (wait_q >= delay_i) begin
        ack_o <= 1'b1;
        wait_q <= 4'h0;
        served_o <= served_o + 1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : tcc_dma_model
`default_nettype wire

/* File: verif/tcc_timer_ctrl_tb_top.sv */
// Purpose: Register-level test of tcc_timer_ctrl
// Assumes: 100 MHz clock, DMA model in place
// Notes:   Counter 0 is preloaded over the bus so underflow is reachable
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_ctrl_tb_top;
  logic         sys_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         wr_i = 1'b0;
  logic         rd_i = 1'b0;
  logic         rtc = 1'b0;
  logic         pin = 1'b0; // pin only ever driven into the block
  logic         stby = 1'b0;
  logic         ack, req, cirq;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic [31:0]  rdata, exp;
  logic [4:0]   start = 5'h00;
  logic [4:0]   uirq;
  logic [3:0]   dly = 4'h1;
  logic [159:0] reload = {5{32'h10}};
  logic [159:0] cnt;
  int unsigned  served;
  int           fail_count = 0;
  int           check_count = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  tcc_timer_ctrl tcc_timer_ctrl_inst (.sys_clk_i, .rst_i, .addr_i(addr), .wr_data_i(wdata),
    .wr_i, .rd_i, .rd_data_o(rdata), .start_i(start), .reload_i(reload), .rtc_tick_i(rtc),
    .timer_clock_pin_i(pin), .standby_i(stby), .dma_ack_i(ack), .dma_req_o(req),
    .capture_irq_o(cirq), .underflow_irq_o(uirq), .counter_o(cnt));
  tcc_dma_model tcc_dma_model_inst (.clk_i(sys_clk_i), .rst_i, .req_i(req), .delay_i(dly),
    .ack_o(ack), .served_o(served));
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      rtc <= 1'b1;
      @(posedge sys_clk_i);
      rtc <= 1'b0;
    end
  endtask : tick
  task automatic pv();
    @(posedge sys_clk_i);
    pin <= ~pin;
    repeat (8) @(posedge sys_clk_i);
  endtask : pv
  task automatic wait_srv(input int unsigned k);
    for (int i = 0; i < 60 && served != k; i++) @(posedge sys_clk_i);
    chk("dma services", k, served);
    if (served != k) end_sim();
  endtask : wait_srv
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    chk("run length", 32'h0, 32'h1);
    end_sim();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    rd(8'hFC, 32'h0);
    wr(8'h00, 32'hFFFF);
    rd(8'h00, 32'h3F);
    wr(8'h08, 32'hFFFF);
    rd(8'h08, 32'hFF);
    wr(8'h0C, 32'hFFFC); // no RTC or pin code on channel 3
    rd(8'h0C, 32'h24);
    wr(8'h00, 32'h6);
    wr(8'h08, 32'hC6);
    wr(8'h0C, 32'h0);
    @(posedge sys_clk_i);
    start <= 5'h05;
    tick(5);
    rd(8'h18, 32'hFFFFFFFA);
    @(posedge sys_clk_i);
    stby <= 1'b1;
    start <= 5'h07;
    tick(2);
    rd(8'h18, 32'hFFFFFFF8);
    rd(8'h1C, 32'hFFFFFFFF);
    @(posedge sys_clk_i);
    stby <= 1'b0;
    start <= 5'h05;
    pv();
    wait_srv(1);
    rd(8'h08, 32'h2C6);
    chk("capture irq", 32'h1, {31'h0, cirq});
    rd(8'h14, 32'hFFFFFFF8);
    tick(1);
    pv();
    pv();
    wait_srv(2);
    rd(8'h14, 32'hFFFFFFF8);
    @(posedge sys_clk_i);
    start <= 5'h00;
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h14, 32'hFFFFFFF8);
    rd(8'h08, 32'h0);
    dly <= 4'hC;
    wr(8'h08, 32'h96);
    pv();
    pv();
    wait_srv(3);
    repeat (30) @(posedge sys_clk_i);
    wait_srv(3);
    chk("capture irq", 32'h0, {31'h0, cirq});
    wr(8'h08, 32'h396);
    rd(8'h08, 32'h296);
    wr(8'h08, 32'h96);
    rd(8'h08, 32'h96);
    dly <= 4'h1;
    wr(8'h08, 32'h56);
    pv();
    wait_srv(3);
    rd(8'h08, 32'h56);
    wr(8'h00, 32'h7);
    @(posedge sys_clk_i);
    start <= 5'h01;
    exp = 32'hFFFFFFFF;
    for (int e = 0; e < 3; e++) begin
      wr(8'h00, 32'h7 | 32'(e << 3));
      pv();
      pv();
      exp = exp - ((e == 2) ? 32'h2 : 32'h1);
      rd(8'h18, exp);
    end
    wr(8'h00, 32'h26);
    wr(8'h18, 32'h1);
    tick(2);
    rd(8'h18, 32'h10);
    rd(8'h00, 32'h126);
    chk("underflow irq", 32'h1, {27'h0, uirq});
    wr(8'h00, 32'h106);
    rd(8'h00, 32'h106);
    chk("underflow irq", 32'h0, {27'h0, uirq});
    wr(8'h00, 32'h6);
    rd(8'h00, 32'h6);
    end_sim();
  end
endmodule : tcc_timer_ctrl_tb_top
`default_nettype wire
